// file: fssr_pkg.sv
// constants shared by the four-stage shift register block
package fssr_pkg;
	// geometry
	localparam int STAGES = 4;
	localparam int FIFO_DEPTH = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FLASH_ON = 8'h08;
	localparam logic [7:0] OFS_FLASH_OFF = 8'h0C;
	// control field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	// status field positions
	localparam int STAT_STAGE_LSB = 0;
	localparam int STAT_SEED_BIT = 4;
	localparam int STAT_PEND_BIT = 5;
	// values after reset
	localparam logic [3:0] STAGE_RST = 4'h0;
	localparam logic CTRL_RUN_RST = 1'b0;
	// timing: clock rate and flasher half periods
	localparam int CLK_KHZ = 200_000;
	localparam int FLASH_ON_MS = 500;
	localparam int FLASH_OFF_MS = 500;
	localparam logic [31:0] FLASH_ON_CYC = 32'(FLASH_ON_MS * CLK_KHZ);
	localparam logic [31:0] FLASH_OFF_CYC = 32'(FLASH_OFF_MS * CLK_KHZ);
endpackage

// file: fssr_oneshot.sv
// rising-edge one-shot with a registered history of its input
`timescale 1ns/100ps
module fssr_oneshot (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// level in, pulse out
	input wire logic i_level,
	output logic o_pulse
);
	logic edge_history_r;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			edge_history_r <= 1'b0;
		end else begin
			edge_history_r <= i_level;
		end
	end

	// high only when the level is high now and was low one cycle before
	assign o_pulse = i_level & ~edge_history_r;

	AST_ONE_CYCLE: assert property (@(posedge i_clk) disable iff (i_rst)
		o_pulse |=> !o_pulse) else $error("strobe lasted more than one cycle");
	AST_NO_RETRIGGER: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_level && $past(i_level)) |-> !o_pulse) else $error("strobe while level held");
endmodule // fssr_oneshot

// file: fssr_fifo.sv
// small shift-style fifo with registered head word and valid
`timescale 1ns/100ps
module fssr_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [CW-1:0] count_r;
	logic push;
	logic pop;
	logic [CW-1:0] wpos;
	logic [CW-1:0] count_nxt;
	logic valid_r;

	assign o_in_ready = (count_r != CW'(DEPTH));
	// valid kept in its own flip-flop so the drain side sees a registered flag
	assign o_out_valid = valid_r;
	assign o_out_data = mem_r[0];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign wpos = count_r - CW'(pop);
	assign count_nxt = count_r + CW'(push) - CW'(pop);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count_r <= '0;
			valid_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			valid_r <= (count_nxt != '0);
		end
	end

	// head moves down on a pop so the head word always sits in a register
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (push && wpos == CW'(i)) begin
				mem_r[i] <= i_in_data;
			end else if (pop && i < DEPTH - 1) begin
				mem_r[i] <= mem_r[i+1];
			end
		end
	end
endmodule // fssr_fifo

// file: fssr_top.sv
// four-stage shift register with running-light mode and apb registers
//
// Notes on behaviour
// - pulse input rising edge makes a shift strobe exactly one cycle long.
// - edge found against a registered copy; stages update the cycle after; a strobe that meets a full fifo shifts only once the fifo has room.
// - held pulse input gives no further strobe until it falls and rises.
// - on a strobe outside running-light mode the first stage takes the value input level.
// - on a strobe stages two to four take the old previous stage together.
// - data move first to second to third to fourth, one step per strobe; further strobes while one waits on a full fifo give no step.
// - between strobes every stage holds its value; a shift held back by a full fifo runs later, between strobes.
// - clear forces all stages to zero and beats a shift in that cycle.
// - each stage is output both true and complemented.
// - running light: four outputs, one on, first to fourth then wrapping.
// - running light pulses come from an internal flasher with set on/off times.
// - first stage seeded with one until it first sets; sticky flag stops seeding.
// - running light: fourth stage feeds the first stage.
// - strobe is input high now and low in the previous cycle.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
module fssr_top #(
	parameter logic [31:0] FLASH_ON_DEF = fssr_pkg::FLASH_ON_CYC,
	parameter logic [31:0] FLASH_OFF_DEF = fssr_pkg::FLASH_OFF_CYC
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	// field inputs, asynchronous to the clock
	input wire logic I_SHIFT_PULSE_IN,
	input wire logic I_VALUE_IN,
	input wire logic I_CLEAR_IN,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [fssr_pkg::ADDR_W-1:0] I_PADDR,
	input wire logic [fssr_pkg::DATA_W-1:0] I_PWDATA,
	output logic [fssr_pkg::DATA_W-1:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// stage outputs
	output logic [fssr_pkg::STAGES-1:0] O_STAGE,
	output logic [fssr_pkg::STAGES-1:0] O_STAGE_N,
	// snapshot stream after each shift
	output logic O_SNAP_VALID,
	input wire logic I_SNAP_READY,
	output logic [fssr_pkg::STAGES-1:0] O_SNAP_DATA
);
	import fssr_pkg::*;

	logic [1:0] pulse_sync_r;
	logic [1:0] value_sync_r;
	logic [1:0] clear_sync_r;
	logic run_mode_r;
	logic soft_clr_r;
	logic [31:0] flash_on_r;
	logic [31:0] flash_off_r;
	logic [31:0] flasher_timer_r;
	logic flash_r;
	logic pulse_src;
	logic shift_strobe;
	logic pending_r;
	logic shift_go;
	logic clear_any;
	logic seed_done_r;
	logic [STAGES-1:0] stage_r;
	logic [STAGES-1:0] stage_n_r;
	logic [STAGES-1:0] stage_nxt;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [STAGES-1:0] fifo_out_data;
	logic snap_push_r;
	logic pready_r;
	logic pslverr_r;
	logic [DATA_W-1:0] prdata_r;
	logic apb_done;
	logic apb_wr;
	logic addr_ok;
	logic flash_end;

	// two flip-flops on each of the three field input pins before any logic; apb and snap_ready pins are used directly
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			pulse_sync_r <= 2'h0;
			value_sync_r <= 2'h0;
			clear_sync_r <= 2'h0;
		end else begin
			pulse_sync_r <= {pulse_sync_r[0], I_SHIFT_PULSE_IN};
			value_sync_r <= {value_sync_r[0], I_VALUE_IN};
			clear_sync_r <= {clear_sync_r[0], I_CLEAR_IN};
		end
	end

	// apb: one wait state, writes land on the completing edge
	assign apb_done = I_PSEL & I_PENABLE & pready_r;
	assign apb_wr = apb_done & I_PWRITE & addr_ok;
	always_comb begin
		case (I_PADDR)
			OFS_CTRL, OFS_STATUS, OFS_FLASH_ON, OFS_FLASH_OFF: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= I_PSEL & I_PENABLE & ~pready_r;
			pslverr_r <= I_PSEL & I_PENABLE & ~pready_r & ~addr_ok;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			prdata_r <= 32'h0000_0000;
		end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
			case (I_PADDR)
				OFS_CTRL: prdata_r <= 32'(run_mode_r);
				OFS_STATUS: prdata_r <= 32'({pending_r, seed_done_r, stage_r});
				OFS_FLASH_ON: prdata_r <= flash_on_r;
				OFS_FLASH_OFF: prdata_r <= flash_off_r;
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// control registers; clear bit is a one-cycle pulse, reads back as zero
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			run_mode_r <= CTRL_RUN_RST;
			soft_clr_r <= 1'b0;
			flash_on_r <= FLASH_ON_DEF;
			flash_off_r <= FLASH_OFF_DEF;
		end else begin
			soft_clr_r <= apb_wr && I_PADDR == OFS_CTRL && I_PWDATA[CTRL_CLR_BIT];
			if (apb_wr && I_PADDR == OFS_CTRL) begin
				run_mode_r <= I_PWDATA[CTRL_RUN_BIT];
			end
			if (apb_wr && I_PADDR == OFS_FLASH_ON) begin
				flash_on_r <= I_PWDATA;
			end
			if (apb_wr && I_PADDR == OFS_FLASH_OFF) begin
				flash_off_r <= I_PWDATA;
			end
		end
	end

	// flasher: high for the on count, low for the off count; idle outside run mode
	assign flash_end = flasher_timer_r + 32'h0000_0001 >= (flash_r ? flash_on_r : flash_off_r);
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || !run_mode_r) begin
			flasher_timer_r <= 32'h0000_0000;
			flash_r <= 1'b0;
		end else if (flash_end) begin
			flasher_timer_r <= 32'h0000_0000;
			flash_r <= ~flash_r;
		end else begin
			flasher_timer_r <= flasher_timer_r + 32'h0000_0001;
		end
	end

	// same edge logic serves the pin and the flasher
	assign pulse_src = run_mode_r ? flash_r : pulse_sync_r[1];

	fssr_oneshot u_oneshot (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.i_level(pulse_src),
		.o_pulse(shift_strobe)
	);

	assign clear_any = clear_sync_r[1] | soft_clr_r;
	// one strobe that meets a full fifo waits here; further strobes while it waits add no extra shift
	assign shift_go = (shift_strobe | pending_r) & fifo_in_ready;

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || clear_any) begin
			pending_r <= 1'b0;
		end else begin
			pending_r <= (shift_strobe | pending_r) & ~fifo_in_ready;
		end
	end

	// next stage contents
	always_comb begin
		stage_nxt = stage_r;
		if (clear_any) begin
			stage_nxt = STAGE_RST;
		end else if (shift_go) begin
			stage_nxt[STAGES-1:1] = stage_r[STAGES-2:0];
			if (run_mode_r) begin
				stage_nxt[0] = stage_r[STAGES-1] | ~seed_done_r;
			end else begin
				stage_nxt[0] = value_sync_r[1];
			end
		end
	end

	// complement kept in its own flip-flops so both outputs are registered
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			stage_r <= STAGE_RST;
			stage_n_r <= ~STAGE_RST;
		end else begin
			stage_r <= stage_nxt;
			stage_n_r <= ~stage_nxt;
		end
	end

	// seed flag: sticky once the first stage has been set
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || clear_any) begin
			seed_done_r <= 1'b0;
		end else if (stage_r[0]) begin
			seed_done_r <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			snap_push_r <= 1'b0;
		end else begin
			snap_push_r <= shift_go & ~clear_any;
		end
	end

	fssr_fifo #(
		.WIDTH(STAGES),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.i_in_valid(snap_push_r),
		.o_in_ready(fifo_in_ready),
		.i_in_data(stage_r),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(I_SNAP_READY),
		.o_out_data(fifo_out_data)
	);

	assign O_PRDATA = prdata_r;
	assign O_PREADY = pready_r;
	assign O_PSLVERR = pslverr_r;
	assign O_STAGE = stage_r;
	assign O_STAGE_N = stage_n_r;
	assign O_SNAP_VALID = fifo_out_valid;
	assign O_SNAP_DATA = fifo_out_data;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	AST_CLEAR_WINS: assert property (clear_any |=> stage_r == STAGE_RST)
		else $error("clear did not empty the stages");
	AST_HOLD: assert property (!shift_go && !clear_any |=> $stable(stage_r))
		else $error("stage changed without a strobe");
	AST_SHIFT_ALL: assert property (shift_go && !clear_any |=> stage_r[3:1] == $past(stage_r[2:0]))
		else $error("stages did not move one place");
	AST_LOAD_VALUE: assert property (shift_go && !clear_any && !run_mode_r
		|=> stage_r[0] == $past(value_sync_r[1]))
		else $error("first stage missed the value");
	AST_RING_BACK: assert property (shift_go && !clear_any && run_mode_r && seed_done_r
		|=> stage_r[0] == $past(stage_r[3]))
		else $error("fourth stage not fed back");
	AST_SEED_STICKY: assert property (seed_done_r && !clear_any |=> seed_done_r)
		else $error("seed flag dropped");
	AST_COMPLEMENT: assert property (O_STAGE_N == ~O_STAGE)
		else $error("complement outputs disagree");
	AST_EDGE_STROBE: assert property ($rose(pulse_src) |-> shift_strobe ##1 !shift_strobe)
		else $error("edge gave no single strobe");

	COV_SHIFT: cover property (shift_go && !run_mode_r && value_sync_r[1]);
	COV_CLEAR: cover property (shift_go && clear_any);
	COV_WRAP: cover property (run_mode_r && stage_r[3] && shift_go);
	COV_STALL: cover property (shift_strobe && !fifo_in_ready);
endmodule // fssr_top

// file: fssr_field_model.sv
// field-side model: pushbuttons on the pulse, value and clear pins
`timescale 1ns/100ps
module fssr_field_model (
	// clock
	input wire logic i_clk,
	// pins toward the block
	output logic o_pulse,
	output logic o_value,
	output logic o_clear
);
	initial begin
		o_pulse = 1'b0;
		o_value = 1'b0;
		o_clear = 1'b0;
	end
	// value settles one edge ahead; pulse held long so a repeat strobe would show
	task automatic press(input logic v, input int hold);
		@(posedge i_clk);
		o_value <= v;
		@(posedge i_clk);
		o_pulse <= 1'b1;
		repeat (hold) @(posedge i_clk);
		o_pulse <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask
	// clear, optionally together with a pulse edge
	task automatic clr(input logic with_pulse);
		@(posedge i_clk);
		o_clear <= 1'b1;
		o_pulse <= with_pulse;
		repeat (6) @(posedge i_clk);
		o_clear <= 1'b0;
		o_pulse <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask
endmodule // fssr_field_model

// file: fssr_top_tb_top.sv
// self-checking bench for the four-stage shift register
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module fssr_top_tb_top;
	import fssr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] stage;
	logic [3:0] stage_n;
	logic snap_valid;
	logic snap_ready = 1'b0;
	logic [3:0] snap_data;
	logic pin_pulse;
	logic pin_value;
	logic pin_clear;
	logic [31:0] rd;
	logic er;
	int checks = 0;
	int miscompares = 0;
	int cyc = 0;
	logic [3:0] exp_tab [5] = '{4'h1, 4'h2, 4'h4, 4'h9, 4'h2};
	logic vals [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	logic [3:0] ring [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
	always #2.5 clk = ~clk;
	fssr_field_model u_fssr_field_model (.i_clk(clk), .o_pulse(pin_pulse), .o_value(pin_value), .o_clear(pin_clear));
	// small flasher times keep the running-light test short
	fssr_top #(.FLASH_ON_DEF(32'h0000_0004), .FLASH_OFF_DEF(32'h0000_0004)) u_fssr_top (
		.I_CLK(clk), .I_SYS_RST(rst), .I_SHIFT_PULSE_IN(pin_pulse), .I_VALUE_IN(pin_value),
		.I_CLEAR_IN(pin_clear), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_STAGE(stage),
		.O_STAGE_N(stage_n), .O_SNAP_VALID(snap_valid), .I_SNAP_READY(snap_ready), .O_SNAP_DATA(snap_data));
	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pop(input logic [3:0] e);
		int n;
		n = 0;
		while (snap_valid !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		`CHK("snap_data", e, snap_data)
		snap_ready <= 1'b1;
		@(posedge clk);
		snap_ready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic next_stage();
		logic [3:0] prev;
		int n;
		prev = stage;
		n = 0;
		while (stage === prev && n < 200) begin
			@(posedge clk);
			n++;
		end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("stage", 4'h0, stage)
		`CHK("stage_n", 4'hF, stage_n)
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHK("status", 32'h0000_0000, rd)
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			u_fssr_field_model.press(vals[i], 8);
			`CHK("stage", exp_tab[i], stage)
			`CHK("stage_n", ~exp_tab[i], stage_n)
		end
		// fifo now full: the next strobe must wait
		u_fssr_field_model.press(vals[4], 8);
		`CHK("stage", 4'h9, stage)
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHK("pending", 1'b1, rd[STAT_PEND_BIT])
		for (int i = 0; i < 5; i++) begin
			pop(exp_tab[i]);
		end
		`CHK("stage", 4'h2, stage)
		$display("test shift done");
		u_fssr_field_model.clr(1'b1);
		`CHK("stage", 4'h0, stage)
		$display("test clear done");
		snap_ready <= 1'b1;
		apb(1'b1, OFS_FLASH_ON, 32'h0000_0004);
		apb(1'b1, OFS_FLASH_OFF, 32'h0000_0004);
		apb(1'b0, OFS_FLASH_ON, 32'h0000_0000);
		`CHK("flash_on", 32'h0000_0004, rd)
		apb(1'b0, 8'h10, 32'h0000_0000);
		`CHK("unmapped_err", 1'b1, er)
		`CHK("unmapped_rd", 32'h0000_0000, rd)
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		`CHK("run_mode", 32'h0000_0001, rd)
		for (int i = 0; i < 5; i++) begin
			next_stage();
			`CHK("ring", ring[i], stage)
		end
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHK("seed_done", 1'b1, rd[STAT_SEED_BIT])
		next_stage();
		`CHK("wrap", 4'h2, stage)
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		`CHK("held", 4'h2, stage)
		apb(1'b1, OFS_CTRL, 32'h0000_0002);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		`CHK("soft_clear", 32'h0000_0000, rd)
		$display("test running light done");
		finish_test();
	end
endmodule // fssr_top_tb_top
